// *** rtl/control_period_sequencer.sv ***
module control_period_sequencer
	import seq_pkg::*;
#(
	parameter int TICK_N = TICK_CYC,
	parameter int PULSE_N = PULSE_CYC,
	parameter int FAST_N = FAST_CYC
)(
	input wire logic CLK_SYS_I,
	input wire logic RESET_I,
	input wire logic CUTOUT_I,
	input wire logic [7:0] AXI_AWADDR_I,
	input wire logic AXI_AWVALID_I,
	output logic AXI_AWREADY_O,
	input wire logic [31:0] AXI_WDATA_I,
	input wire logic [3:0] AXI_WSTRB_I,
	input wire logic AXI_WVALID_I,
	output logic AXI_WREADY_O,
	output logic [1:0] AXI_BRESP_O,
	output logic AXI_BVALID_O,
	input wire logic AXI_BREADY_I,
	input wire logic [7:0] AXI_ARADDR_I,
	input wire logic AXI_ARVALID_I,
	output logic AXI_ARREADY_O,
	output logic [31:0] AXI_RDATA_O,
	output logic [1:0] AXI_RRESP_O,
	output logic AXI_RVALID_O,
	input wire logic AXI_RREADY_I,
	output logic [3:0] ROUTE_O,
	output logic [3:0] LAMP_O,
	output logic [15:0] PANEL_LAMP_O,
	output logic TIMER_ON_O,
	output logic NORMAL_O,
	output logic EXTENDED_O,
	output logic BYPASS_O
);
	// ----------------------------------------------------------------
	// Register decode helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] reg_sel(input logic [7:0] a);
		logic [2:0] r;
		r = 3'h0;
		case (a)
			CTRL_OFS: r = 3'h4;
			PASS_OFS: r = 3'h5;
			SEQ_MAP_OFS: r = 3'h6;
			STATUS_OFS: r = 3'h7;
			default: r = 3'h0;
		endcase
		return r;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
			if (be[b])
				r[8*b +: 8] = nw[8*b +: 8];
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Cutout synchroniser
	// ----------------------------------------------------------------
	logic cut_s1_q, cut_s2_q, cut_s3_q;
	logic cut_q, cut_d;

	// A change is only believed once two stages agree, which rejects a single
	// metastable sample on the slow relay-driven line.
	always_comb
	begin
		cut_d = (cut_s2_q == cut_s3_q) ? cut_s3_q : cut_q;
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (RESET_I)
		begin
			cut_s1_q <= 1'b0;
			cut_s2_q <= 1'b0;
			cut_s3_q <= 1'b0;
			cut_q <= 1'b0;
		end
		else
		begin
			cut_s1_q <= CUTOUT_I;
			cut_s2_q <= cut_s1_q;
			cut_s3_q <= cut_s2_q;
			cut_q <= cut_d;
		end
	end

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	logic [31:0] ctrl_q, ctrl_d, pass_q, pass_d, map_q, map_d;
	logic aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d, status;
	logic [2:0] wsel, rsel;

	assign AXI_AWREADY_O = !aw_have_q && !bvalid_q;
	assign AXI_WREADY_O = !w_have_q && !bvalid_q;
	assign AXI_ARREADY_O = !rvalid_q;

	always_comb
	begin
		ctrl_d = ctrl_q;
		pass_d = pass_q;
		map_d = map_q;
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		wsel = reg_sel(awaddr_q);
		rsel = reg_sel(AXI_ARADDR_I);
		if (AXI_AWVALID_I && AXI_AWREADY_O)
		begin
			aw_have_d = 1'b1;
			awaddr_d = AXI_AWADDR_I;
		end
		if (AXI_WVALID_I && AXI_WREADY_O)
		begin
			w_have_d = 1'b1;
			wdata_d = AXI_WDATA_I;
			wstrb_d = AXI_WSTRB_I;
		end
		if (aw_have_q && w_have_q)
		begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = wsel[2] ? RESP_OKAY : RESP_SLVERR;
			case (wsel)
				3'h4: ctrl_d = merge(ctrl_q, wdata_q, wstrb_q);
				3'h5: pass_d = merge(pass_q, wdata_q, wstrb_q);
				3'h6: map_d = merge(map_q, wdata_q, wstrb_q);
				default: ;
			endcase
		end
		else if (bvalid_q && AXI_BREADY_I)
			bvalid_d = 1'b0;
		if (AXI_ARVALID_I && AXI_ARREADY_O)
		begin
			rvalid_d = 1'b1;
			rresp_d = rsel[2] ? RESP_OKAY : RESP_SLVERR;
			case (rsel)
				3'h4: rdata_d = ctrl_q;
				3'h5: rdata_d = pass_q;
				3'h6: rdata_d = map_q;
				3'h7: rdata_d = status;
				default: rdata_d = '0;
			endcase
		end
		else if (rvalid_q && AXI_RREADY_I)
			rvalid_d = 1'b0;
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (RESET_I)
		begin
			ctrl_q <= CTRL_RESET;
			pass_q <= PASS_RESET;
			map_q <= SEQ_MAP_RESET;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= '0;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			pass_q <= pass_d;
			map_q <= map_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

	assign AXI_BVALID_O = bvalid_q;
	assign AXI_BRESP_O = bresp_q;
	assign AXI_RVALID_O = rvalid_q;
	assign AXI_RRESP_O = rresp_q;
	assign AXI_RDATA_O = rdata_q;

	// ----------------------------------------------------------------
	// Sequencing and control condition
	// ----------------------------------------------------------------
	timer_if tmr();
	ctl_state_t state_q, state_d;
	logic [1:0] seq_q, seq_d;
	logic byp_q, byp_d;
	logic [3:0] route_q, route_d;
	logic warn, auto_seq, pass, deliver;
	logic [2:0] man_sel;
	logic [1:0] seq_station;
	logic [6:0] ivl_raw;

	assign warn = ctrl_q[CTRL_WARN_BIT];
	assign man_sel = ctrl_q[CTRL_MAN_LSB +: 3];
	assign ivl_raw = ctrl_q[CTRL_IVL_LSB +: 7];
	assign auto_seq = (man_sel == 3'h0);
	assign seq_station = map_q[2*seq_q +: 2];
	assign pass = pass_q[4 + seq_q] | pass_q[seq_station];

	always_comb
	begin
		tmr.power = ctrl_q[CTRL_POWER_BIT];
		tmr.interval = (ivl_raw < IVL_MIN_S) ? IVL_MIN_S : (ivl_raw > IVL_MAX_S) ? IVL_MAX_S : ivl_raw;
		tmr.fast = (state_q == ST_EXTENDED) && warn;
		// The force is ignored by the timer itself while its pulse runs, and
		// bypass falls once that pulse has stepped the sequence.
		tmr.force_pulse = byp_q;
	end

	always_comb
	begin
		deliver = tmr.pulse_start && (state_q == ST_NORMAL) && !cut_q && auto_seq;
		seq_d = deliver ? seq_q + 2'h1 : seq_q;
		byp_d = auto_seq && !cut_q && pass && !deliver;
		state_d = state_q;
		if (byp_q)
			state_d = ST_NORMAL;
		else if (!warn)
			state_d = ST_NORMAL;
		else
		begin
			unique case (state_q)
				ST_NORMAL: state_d = ST_ARMED;
				ST_ARMED: state_d = (tmr.pulse_start && !cut_q) ? ST_EXTENDED : ST_ARMED;
				ST_EXTENDED: state_d = ST_EXTENDED;
				default: state_d = ST_NORMAL;
			endcase
		end
		route_d = '0;
		if (!cut_q)
		begin
			if (auto_seq)
				route_d[seq_station] = !pass;
			else if (man_sel <= 3'h4)
				route_d[man_sel[1:0] - 2'h1] = 1'b1;
		end
	end

	always_ff @(posedge CLK_SYS_I)
	begin
		if (RESET_I)
		begin
			state_q <= ST_NORMAL;
			seq_q <= '0;
			byp_q <= 1'b0;
			route_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			seq_q <= seq_d;
			byp_q <= byp_d;
			route_q <= route_d;
		end
	end

	interval_pulse_stage #(
		.TICK_N(TICK_N),
		.PULSE_N(PULSE_N),
		.FAST_N(FAST_N)
	) u_timer (
		.clk_i(CLK_SYS_I),
		.rst_i(RESET_I),
		.tmr(tmr)
	);

	indicator_blinker u_lamps (
		.clk_i(CLK_SYS_I),
		.rst_i(RESET_I),
		.held_i(route_q),
		.extended_i(state_q == ST_EXTENDED),
		.tick_i(tmr.pulse_start),
		.lamp_o(LAMP_O),
		.panel_o(PANEL_LAMP_O)
	);

	assign ROUTE_O = route_q;
	assign TIMER_ON_O = tmr.power;
	assign NORMAL_O = (state_q == ST_NORMAL);
	assign EXTENDED_O = (state_q == ST_EXTENDED);
	assign BYPASS_O = byp_q;
	assign status = {20'h0_0000, LAMP_O, 2'h0, seq_q, cut_q, byp_q, EXTENDED_O, NORMAL_O};

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RESET_I);

	logic [31:0] pw_q;
	always_ff @(posedge CLK_SYS_I)
	begin
		if (RESET_I)
			pw_q <= '0;
		else
			pw_q <= tmr.pulse ? pw_q + 32'h0000_0001 : 32'h0000_0000;
	end

	sequence bypass_begins;
		$rose(byp_q) && tmr.power && !tmr.pulse;
	endsequence
	sequence pulse_fires;
		tmr.pulse_start && tmr.pulse;
	endsequence

	bypass_on_pass_a: assert property (auto_seq && !cut_q && pass && !deliver |=> byp_q && route_q == 4'h0)
		else $error("passed sequence not bypassed");
	auto_forces_normal_a: assert property (!warn |=> NORMAL_O && !EXTENDED_O)
		else $error("auto selector did not hold normal control");
	bypass_pulse_a: assert property (bypass_begins |-> ##1 pulse_fires)
		else $error("bypass did not force a timing pulse");
	ext_bypass_normal_a: assert property (EXTENDED_O && byp_q |=> NORMAL_O)
		else $error("bypass did not end extended control");
	rearm_after_bypass_a: assert property ($fell(byp_q) && warn && NORMAL_O |=> state_q == ST_ARMED)
		else $error("warn not re-armed after bypass");
	grant_extended_a: assert property (state_q == ST_ARMED && warn && !byp_q && tmr.pulse_start && !cut_q
		|=> EXTENDED_O && $stable(seq_q))
		else $error("extended control not granted at expiry");
	pulse_width_a: assert property ($fell(tmr.pulse) |-> pw_q == 32'(PULSE_N))
		else $error("timing pulse width wrong");
	step_on_pulse_a: assert property (tmr.pulse_start && NORMAL_O && !cut_q && auto_seq
		|=> seq_q == $past(seq_q) + 2'h1)
		else $error("normal pulse did not step the sequence");
	fast_no_step_a: assert property (EXTENDED_O && warn |-> tmr.fast ##1 $stable(seq_q))
		else $error("extended pulses stepped the sequence");
	cutout_hold_a: assert property (cut_q && tmr.pulse_start |=> $stable(seq_q))
		else $error("pulse delivered during cutout");
	cutout_route_a: assert property (cut_q |=> route_q == 4'h0)
		else $error("station routed during cutout");
	exclusive_cond_a: assert property (!(NORMAL_O && EXTENDED_O))
		else $error("normal and extended both asserted");
	auto_ends_ext_a: assert property (EXTENDED_O && !warn |=> NORMAL_O && $stable(seq_q))
		else $error("auto did not end extended cleanly");
	reset_state_a: assert property (@(posedge CLK_SYS_I) disable iff (1'b0)
		RESET_I |=> NORMAL_O && !byp_q && seq_q == 2'h0 && !tmr.pulse)
		else $error("reset state wrong");
endmodule

// *** rtl/seq_pkg.sv ***
package seq_pkg;
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] PASS_OFS = 8'h04;
	localparam logic [7:0] SEQ_MAP_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0C;
	localparam int CTRL_WARN_BIT = 0;
	localparam int CTRL_POWER_BIT = 1;
	localparam int CTRL_MAN_LSB = 2;
	localparam int CTRL_IVL_LSB = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_3202;
	localparam logic [31:0] PASS_RESET = 32'h0000_0000;
	localparam logic [31:0] SEQ_MAP_RESET = 32'h0000_00E4;
	localparam int ST_NORMAL_BIT = 0;
	localparam int ST_EXTENDED_BIT = 1;
	localparam int ST_BYPASS_BIT = 2;
	localparam int ST_CUTOUT_BIT = 3;
	localparam int ST_SEQ_LSB = 4;
	localparam int ST_LAMP_LSB = 8;
	localparam int CLK_KHZ = 125_000;
	localparam int PULSE_MS = 40;
	localparam int PULSE_CYC = PULSE_MS * CLK_KHZ;
	localparam int FAST_MS = 250;
	localparam int FAST_CYC = FAST_MS * CLK_KHZ;
	localparam int TICK_CYC = CLK_KHZ * 1000;
	localparam logic [6:0] IVL_MIN_S = 7'h14;
	localparam logic [6:0] IVL_MAX_S = 7'h5A;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		ST_NORMAL = 2'b00,
		ST_ARMED = 2'b01,
		ST_EXTENDED = 2'b10
	} ctl_state_t;
endpackage

// *** rtl/timer_if.sv ***
interface timer_if;
	logic power;
	logic fast;
	logic force_pulse;
	logic [6:0] interval;
	logic pulse;
	logic pulse_start;
	modport ctrl(output power, output fast, output force_pulse, output interval, input pulse, input pulse_start);
	modport timer(input power, input fast, input force_pulse, input interval, output pulse, output pulse_start);
endinterface

// *** rtl/interval_pulse_stage.sv ***
module interval_pulse_stage
	import seq_pkg::*;
#(
	parameter int TICK_N = TICK_CYC,
	parameter int PULSE_N = PULSE_CYC,
	parameter int FAST_N = FAST_CYC
)(
	input wire logic clk_i,
	input wire logic rst_i,
	timer_if.timer tmr
);
	logic [31:0] cnt_q, cnt_d;
	logic [6:0] sec_q, sec_d;
	logic pulse_q, pulse_d;
	logic start_q, start_d;

	always_comb
	begin
		cnt_d = cnt_q;
		sec_d = sec_q;
		pulse_d = pulse_q;
		start_d = 1'b0;
		if (pulse_q)
		begin
			if (cnt_q >= 32'(PULSE_N - 1))
			begin
				pulse_d = 1'b0;
				cnt_d = '0;
			end
			else
				cnt_d = cnt_q + 32'h0000_0001;
		end
		else if (!tmr.power)
		begin
			cnt_d = '0;
			sec_d = '0;
		end
		else if (tmr.force_pulse)
			start_d = 1'b1;
		else if (tmr.fast)
		begin
			if (cnt_q >= 32'(FAST_N - 1))
				start_d = 1'b1;
			else
				cnt_d = cnt_q + 32'h0000_0001;
		end
		else if (cnt_q >= 32'(TICK_N - 1))
		begin
			cnt_d = '0;
			if (sec_q + 7'h01 >= tmr.interval)
				start_d = 1'b1;
			else
				sec_d = sec_q + 7'h01;
		end
		else
			cnt_d = cnt_q + 32'h0000_0001;
		if (start_d)
		begin
			pulse_d = 1'b1;
			cnt_d = '0;
			sec_d = '0;
		end
	end

	// Reset restarts the interval from zero.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_q <= '0;
			sec_q <= '0;
			pulse_q <= 1'b0;
			start_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			sec_q <= sec_d;
			pulse_q <= pulse_d;
			start_q <= start_d;
		end
	end

	assign tmr.pulse = pulse_q;
	assign tmr.pulse_start = start_q;
endmodule

// *** rtl/indicator_blinker.sv ***
module indicator_blinker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] held_i,
	input wire logic extended_i,
	input wire logic tick_i,
	output logic [3:0] lamp_o,
	output logic [15:0] panel_o
);
	logic blink_q, blink_d;
	logic [3:0] lamp_q, lamp_d;

	// Bit 0 blue, bit 1 amber, bit 2 green, bit 3 white.
	always_comb
	begin
		blink_d = extended_i ? (blink_q ^ tick_i) : 1'b0;
		lamp_d = held_i & ~{4{blink_q}};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			blink_q <= 1'b0;
			lamp_q <= '0;
		end
		else
		begin
			blink_q <= blink_d;
			lamp_q <= lamp_d;
		end
	end

	assign lamp_o = lamp_q;
	for (genvar p = 0; p < 4; p++)
	begin : g_panel
		assign panel_o[4*p +: 4] = lamp_q;
	end
endmodule

// *** tb/station_model.sv ***
// ----------------------------------------
// Height-finder switch box at the far side.
// ----------------------------------------
module station_model (
	input wire logic clk_i,
	input wire logic takeover_i,
	output logic cutout_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// The pin is asynchronous to the block, so it is moved off the edge on purpose.
	initial cutout_o = 1'b0;
	always @(posedge clk_i)
		cutout_o <= #2 takeover_i;
endmodule

// *** tb/tb.sv ***
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import seq_pkg::*;
	// ----------------------------------------
	// Signals and instances.
	// ----------------------------------------
	localparam int TK = 10;
	logic clk, rst, takeover, cutout;
	logic [7:0] awaddr, araddr;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic [31:0] wdata, rdata, rd_d;
	logic [3:0] wstrb, route, lamp, r, route_seen, r_ref;
	logic [15:0] panel;
	logic awready, wready, bvalid, arready, rvalid, timer_on, normal, extended, bypass, byp_seen, lamp_dark;
	logic [1:0] bresp, rresp, wr_r, rd_r;
	int num_errors, num_checks, n;
	station_model partner (.clk_i(clk), .takeover_i(takeover), .cutout_o(cutout));
	control_period_sequencer #(.TICK_N(TK), .PULSE_N(3), .FAST_N(4)) uut (
		.CLK_SYS_I(clk), .RESET_I(rst), .CUTOUT_I(cutout),
		.AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid), .AXI_AWREADY_O(awready),
		.AXI_WDATA_I(wdata), .AXI_WSTRB_I(wstrb), .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready),
		.AXI_BRESP_O(bresp), .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready),
		.AXI_ARADDR_I(araddr), .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready),
		.AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid), .AXI_RREADY_I(rready),
		.ROUTE_O(route), .LAMP_O(lamp), .PANEL_LAMP_O(panel), .TIMER_ON_O(timer_on),
		.NORMAL_O(normal), .EXTENDED_O(extended), .BYPASS_O(bypass));
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// ----------------------------------------
	// Reporting, bus and wait tasks.
	// ----------------------------------------
	task results();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task bad(input string m);
		num_errors++;
		$display("BAD %0t %s", $time, m);
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp)
			bad(m);
	endtask
	function automatic logic [3:0] rot(input logic [3:0] v);
		return {v[2:0], v[3]};
	endfunction
	function automatic logic hit(input int sel);
		case (sel)
			0: return route !== r_ref && route !== 4'h0;
			1: return extended === 1'b1;
			2: return normal === 1'b0;
			default: return route !== 4'h0;
		endcase
	endfunction
	// Bounded wait; n holds the cycles spent.
	task wt(input int sel, input int lim);
		n = 0;
		while (!hit(sel))
		begin
			@(posedge clk);
			#1;
			n++;
			if (n > lim)
			begin
				bad("wait ran out");
				results();
			end
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 50; i++)
		begin
			@(posedge clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				wr_r = bresp;
				bready <= 1'b0;
				return;
			end
		end
		bad("no write answer");
		results();
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 50; i++)
		begin
			@(posedge clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				rd_d = rdata;
				rd_r = rresp;
				rready <= 1'b0;
				return;
			end
		end
		bad("no read answer");
		results();
	endtask
	task clr();
		@(negedge clk);
		route_seen = 4'h0;
		byp_seen = 1'b0;
		lamp_dark = 1'b0;
	endtask
	always @(posedge clk)
		if (!rst)
		begin
			route_seen <= route_seen | route;
			if (bypass)
				byp_seen <= 1'b1;
			if (extended && route != 4'h0 && lamp == 4'h0)
				lamp_dark <= 1'b1;
			if (normal === 1'b1 && extended === 1'b1)
				bad("normal and extended together");
			if (panel !== {4{lamp}})
				bad("panel lamps differ");
		end
	// ----------------------------------------
	// Main sequence.
	// ----------------------------------------
	initial
	begin
		{rst, takeover, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
		{awaddr, araddr, wdata, num_errors, num_checks} = '0;
		wstrb = 4'hF;
		route_seen = 4'h0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk({route, normal, extended, bypass, timer_on}, 32'h0000_0019, "reset outputs");
		rd(CTRL_OFS);
		chk(rd_d, CTRL_RESET, "ctrl reset");
		rd(PASS_OFS);
		chk(rd_d, PASS_RESET, "pass reset");
		rd(SEQ_MAP_OFS);
		chk(rd_d, SEQ_MAP_RESET, "map reset");
		rd(STATUS_OFS);
		chk(rd_d & 32'h0000_000F, 32'h0000_0001, "status normal");
		rd(8'h40);
		chk({30'h0, rd_r}, {30'h0, RESP_SLVERR}, "unmapped read");
		wr(8'h40, 32'h0000_0001);
		chk({30'h0, wr_r}, {30'h0, RESP_SLVERR}, "unmapped write");
		$display("registers done");
		wr(CTRL_OFS, 32'h0000_1402);
		r_ref = 4'h1;
		wt(0, 700);
		r = route;
		r_ref = r;
		wt(0, 400);
		chk({31'h0, n inside {[20 * TK - 8:20 * TK + 8]}}, 32'h0000_0001, "interval length");
		chk(route, rot(r), "step once");
		@(posedge clk);
		#1;
		chk(lamp, route, "lamp follows");
		$display("sequencing done");
		r = route;
		r_ref = r;
		clr();
		wr(PASS_OFS, {28'h0, r});
		wt(0, 20);
		chk(route, rot(r), "bypass advances");
		repeat (4) @(posedge clk);
		#1;
		chk({byp_seen, bypass}, 32'h0000_0002, "bypass pulse");
		r = route;
		r_ref = r;
		clr();
		wr(PASS_OFS, {24'h0, rot(r), 4'h0});
		wt(0, 400);
		chk(route, rot(rot(r)), "passed sequence skipped");
		chk(route_seen & rot(r), 4'h0, "passed station routed");
		wr(PASS_OFS, 32'h0000_0000);
		$display("bypass done");
		wr(CTRL_OFS, 32'h0000_1403);
		wt(2, 10);
		wt(1, 400);
		r = route;
		clr();
		repeat (300) @(posedge clk);
		#1;
		chk(route, r, "fast pulses held");
		chk(lamp_dark, 1'b1, "lamp flashes");
		r_ref = r;
		wr(PASS_OFS, {28'h0, r});
		wt(0, 20);
		chk({route, extended}, {rot(r), 1'b0}, "bypass ends extended");
		wr(PASS_OFS, 32'h0000_0000);
		#1;
		chk({bypass, normal, extended}, 32'h0000_0000, "re-armed");
		r = route;
		wt(1, 400);
		chk(route, r, "next gets extended");
		wr(CTRL_OFS, 32'h0000_1402);
		repeat (3) @(posedge clk);
		#1;
		chk({route, normal, extended}, {r, 2'b10}, "auto ends extended");
		r_ref = r;
		wt(0, 400);
		chk(route, rot(r), "transfer at pulse");
		$display("warn done");
		r = route;
		@(posedge clk);
		takeover <= 1'b1;
		repeat (10) @(posedge clk);
		clr();
		repeat (450) @(posedge clk);
		wr(CTRL_OFS, 32'h0000_140A);
		repeat (10) @(posedge clk);
		#1;
		chk(route_seen, 4'h0, "cutout blocks");
		wr(CTRL_OFS, 32'h0000_1402);
		@(posedge clk);
		takeover <= 1'b0;
		wt(3, 20);
		chk(route, r, "control returned");
		r_ref = r;
		wt(0, 250);
		chk(route, rot(r), "timer kept running");
		$display("cutout done");
		wr(CTRL_OFS, 32'h0000_140A);
		repeat (5) @(posedge clk);
		#1;
		chk({route, lamp}, 8'h22, "manual amber");
		wr(CTRL_OFS, 32'h0000_1408);
		repeat (3) @(posedge clk);
		#1;
		chk(timer_on, 1'b0, "timer off");
		$display("manual done");
		results();
	end
endmodule
